/* hw/pdc_channel.sv */
// pwm duty cycle channel with ahb-lite register slave
// Notes on behaviour
// [RULE1] duty is 10 bits: upper byte plus two fraction bits in channel control
// [RULE2] duty writes accepted anytime, used only after period match reload
// [RULE3] in pulse-width mode the shadow byte is read only
// [RULE4] shadow byte plus hidden 2-bit latch double-buffer the duty value
// [RULE5] pin cleared when buffered duty equals counter with two phase bits
// [RULE6] duty longer than period never clears the pin
// [RULE7] high time is duty times clock times prescale of 1, 4 or 16
// [RULE8] software sets period, duty, pin direction, prescaler, then mode
// [RULE9] after counter equals limit: clear counter, set pin unless duty zero, reload
// [RULE10] clearing channel control forces output latch low
// [RULE11] prescale select 00 is /1, 01 is /4, 1x is /16
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pdc_channel
   import pdc_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // pin
   output logic PWM_OUT,
   output logic PWM_OE
);
   pdc_req_t req_ff;
   logic [7:0] count_ff;
   logic [7:0] limit_ff;
   logic [6:0] cntctl_ff;
   logic [7:0] dutyhi_ff;
   logic [7:0] shadow_ff;
   logic [1:0] frac_latch_ff;
   logic [5:0] chctl_ff;
   logic pin_dir_ff;
   logic [5:0] pre_ff;
   logic out_ff;
   logic [31:0] rdata_ff;
   logic wr_go;
   logic tick;
   logic pwm_mode;
   logic period_end;
   logic [5:0] pre_last;
   logic [1:0] cmp_low;
   logic step_end;
   logic [10:0] next_pos;
   logic [9:0] active_duty;

   function automatic logic is_addr(input pdc_req_t r, input logic [7:0] a);
      is_addr = r.sel && (r.addr == a);
   endfunction

   // prescaler count at which the counter steps
   function automatic logic [5:0] step_last(input logic [1:0] ps);
      case (ps)
         PDC_PS_DIV1: step_last = PDC_DIV1_LAST;
         PDC_PS_DIV4: step_last = PDC_DIV4_LAST;
         default: step_last = PDC_DIV16_LAST;
      endcase
   endfunction

   // quarter-step bits appended below the counter
   function automatic logic [1:0] quarter_of(input logic [1:0] ps, input logic [5:0] pre);
      case (ps)
         PDC_PS_DIV1: quarter_of = pre[1:0];
         PDC_PS_DIV4: quarter_of = pre[3:2];
         default: quarter_of = pre[5:4];
      endcase
   endfunction

   // last clock of the current quarter step
   function automatic logic quarter_done(input logic [1:0] ps, input logic [5:0] pre);
      case (ps)
         PDC_PS_DIV1: quarter_done = 1'b1;
         PDC_PS_DIV4: quarter_done = (pre[1:0] == 2'h3);
         default: quarter_done = (pre[3:0] == 4'hf);
      endcase
   endfunction

   assign wr_go = req_ff.sel && req_ff.write;
   assign pwm_mode = (chctl_ff[3:2] == PDC_MODE_PWM);
   // [RULE11]
   assign pre_last = step_last(cntctl_ff[1:0]);
   assign tick = cntctl_ff[PDC_RUN_BIT] && (pre_ff == pre_last);
   assign period_end = tick && (count_ff == limit_ff);
   // low compare bits: one quarter step per prescaled clock
   assign cmp_low = quarter_of(cntctl_ff[1:0], pre_ff);
   assign step_end = quarter_done(cntctl_ff[1:0], pre_ff);
   // position reached at this edge; matching it keeps the high time exact
   assign next_pos = {1'b0, count_ff, cmp_low} + 11'h001;
   assign active_duty = {shadow_ff, frac_latch_ff}; // [RULE4]

   // address phase capture; zero wait states
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         req_ff <= '0;
      end else if (HREADY) begin
         req_ff.sel <= HSEL && (HTRANS == PDC_HTRANS_NONSEQ) && (HSIZE == 3'h2);
         req_ff.write <= HWRITE;
         req_ff.addr <= HADDR[7:0];
      end else begin
         req_ff.sel <= 1'b0;
      end
   end

   // software-written registers
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         limit_ff <= PDC_RST_LIMIT;
         cntctl_ff <= 7'h00;
         dutyhi_ff <= PDC_RST_BYTE;
         chctl_ff <= 6'h00;
         pin_dir_ff <= 1'b0;
      end else if (wr_go) begin
         if (is_addr(req_ff, PDC_ADDR_LIMIT)) limit_ff <= HWDATA[7:0];
         if (is_addr(req_ff, PDC_ADDR_CNTCTL)) cntctl_ff <= HWDATA[6:0];
         if (is_addr(req_ff, PDC_ADDR_DUTYHI)) dutyhi_ff <= HWDATA[7:0]; // [RULE2]
         if (is_addr(req_ff, PDC_ADDR_CHCTL)) chctl_ff <= HWDATA[5:0]; // [RULE1]
         if (is_addr(req_ff, PDC_ADDR_PIN)) pin_dir_ff <= HWDATA[PDC_PIN_DIR_BIT];
      end
   end

   // prescaler runs only while the counter is enabled
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pre_ff <= 6'h00;
      end else if (!cntctl_ff[PDC_RUN_BIT] || tick) begin
         pre_ff <= 6'h00;
      end else begin
         pre_ff <= pre_ff + 6'h01;
      end
   end

   // period counter; software write wins over counting
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         count_ff <= PDC_RST_BYTE;
      end else if (wr_go && is_addr(req_ff, PDC_ADDR_COUNT)) begin
         count_ff <= HWDATA[7:0];
      end else if (period_end) begin
         count_ff <= PDC_RST_BYTE; // [RULE9]
      end else if (tick) begin
         count_ff <= count_ff + 8'h01;
      end
   end

   // shadow reload at period end in pwm mode; software write only outside pwm mode
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         shadow_ff <= PDC_RST_BYTE;
         frac_latch_ff <= 2'h0;
      end else if (pwm_mode && period_end) begin
         shadow_ff <= dutyhi_ff; // [RULE9]
         frac_latch_ff <= chctl_ff[PDC_FRAC_LSB +: 2]; // [RULE2]
      end else if (!pwm_mode && wr_go && is_addr(req_ff, PDC_ADDR_SHADOW)) begin
         shadow_ff <= HWDATA[7:0]; // [RULE3]
      end
   end

   // output latch; set and clear use the duty of the period starting
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         out_ff <= 1'b0;
      end else if (chctl_ff == 6'h00) begin
         out_ff <= 1'b0; // [RULE10]
      end else if (!pwm_mode) begin
         out_ff <= out_ff;
      end else if (period_end) begin
         out_ff <= ({dutyhi_ff, chctl_ff[PDC_FRAC_LSB +: 2]} != 10'h000); // [RULE9]
      end else if (cntctl_ff[PDC_RUN_BIT] && step_end && ({1'b0, active_duty} == next_pos)) begin
         // never matches if duty exceeds the period, so pin stays high
         out_ff <= 1'b0; // [RULE5] [RULE6] [RULE7]
      end
   end

   // pin driven in pwm mode when direction bit clear, matching the port convention
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         PWM_OUT <= 1'b0;
         PWM_OE <= 1'b0;
      end else begin
         PWM_OUT <= out_ff;
         PWM_OE <= !pin_dir_ff && pwm_mode; // [RULE8]
      end
   end

   // read data, registered one edge ahead of the data phase end
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rdata_ff <= 32'h0;
      end else if (HREADY && HSEL && !HWRITE && (HTRANS == PDC_HTRANS_NONSEQ)) begin
         case (HADDR[7:0])
            PDC_ADDR_COUNT: rdata_ff <= {24'h0, count_ff};
            PDC_ADDR_LIMIT: rdata_ff <= {24'h0, limit_ff};
            PDC_ADDR_CNTCTL: rdata_ff <= {25'h0, cntctl_ff};
            PDC_ADDR_DUTYHI: rdata_ff <= {24'h0, dutyhi_ff};
            PDC_ADDR_SHADOW: rdata_ff <= {24'h0, shadow_ff};
            PDC_ADDR_CHCTL: rdata_ff <= {26'h0, chctl_ff};
            PDC_ADDR_PIN: rdata_ff <= {31'h0, pin_dir_ff};
            default: rdata_ff <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   assign HRDATA = rdata_ff;
endmodule
`default_nettype wire

/* hw/pdc_pkg.sv */
// package for the pwm duty cycle channel
package pdc_pkg;
   // register byte addresses (no offsets printed; chosen)
   localparam logic [7:0] PDC_ADDR_COUNT = 8'h00;
   localparam logic [7:0] PDC_ADDR_LIMIT = 8'h04;
   localparam logic [7:0] PDC_ADDR_CNTCTL = 8'h08;
   localparam logic [7:0] PDC_ADDR_DUTYHI = 8'h0c;
   localparam logic [7:0] PDC_ADDR_SHADOW = 8'h10;
   localparam logic [7:0] PDC_ADDR_CHCTL = 8'h14;
   localparam logic [7:0] PDC_ADDR_PIN = 8'h18;
   // field positions
   localparam int PDC_FRAC_LSB = 4;
   localparam int PDC_RUN_BIT = 2;
   localparam int PDC_PIN_DIR_BIT = 0;
   // reset values
   localparam logic [7:0] PDC_RST_BYTE = 8'h00;
   localparam logic [7:0] PDC_RST_LIMIT = 8'hff;
   localparam logic [1:0] PDC_RST_PHASE = 2'h0;
   // pulse-width mode code in channel_mode_sel
   localparam logic [1:0] PDC_MODE_PWM = 2'h3;
   // prescale selections and divisors
   localparam logic [1:0] PDC_PS_DIV1 = 2'h0;
   localparam logic [1:0] PDC_PS_DIV4 = 2'h1;
   // last prescaler count of one counter step: four quarter steps per count
   localparam logic [5:0] PDC_DIV1_LAST = 6'h03;
   localparam logic [5:0] PDC_DIV4_LAST = 6'h0f;
   localparam logic [5:0] PDC_DIV16_LAST = 6'h3f;
   localparam logic [1:0] PDC_HTRANS_NONSEQ = 2'h2;
   // ahb address phase carrier
   typedef struct packed {
      logic sel;
      logic write;
      logic [7:0] addr;
   } pdc_req_t;
endpackage

/* bench/pdc_pin_model.sv */
// external load on the pwm pin that measures pulse widths
`timescale 1ns/1ps
`default_nettype none
module pdc_pin_model (
   // clock and pin
   input wire logic clk,
   input wire logic pin_out,
   input wire logic pin_oe,
   // measured width of the last high pulse
   output logic [15:0] last_high
);
   logic pin;
   logic [15:0] run_len = 16'h0;
   // an undriven pin falls to the load's pull-down
   assign pin = pin_oe ? pin_out : 1'b0;
   always @(posedge clk) begin
      if (pin === 1'b1) begin
         run_len <= run_len + 16'h1;
      end else begin
         if (run_len != 16'h0) last_high <= run_len;
         run_len <= 16'h0;
      end
   end
endmodule
`default_nettype wire

/* bench/pdc_channel_sva.sv */
// assertion checker for the pwm duty cycle channel
`timescale 1ns/1ps
`default_nettype none
module pdc_channel_sva
   import pdc_pkg::*;
(
   // clock, reset and bus
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   // pin
   input wire logic PWM_OUT,
   input wire logic PWM_OE
);
   logic ap_ok, wr_q, rd_q;
   logic [7:0] addr_q, du_m, cnt_m;
   logic [5:0] ch_m;
   assign ap_ok = HSEL && HREADY && HTRANS == PDC_HTRANS_NONSEQ;
   // mirrors of what software wrote, landed at the end of the data phase
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 8'h00;
         du_m <= 8'h00;
         cnt_m <= 8'h00;
         ch_m <= 6'h00;
      end else begin
         wr_q <= ap_ok && HWRITE;
         rd_q <= ap_ok && !HWRITE;
         addr_q <= HADDR[7:0];
         if (wr_q && addr_q == PDC_ADDR_DUTYHI) du_m <= HWDATA[7:0];
         if (wr_q && addr_q == PDC_ADDR_CNTCTL) cnt_m <= HWDATA[7:0];
         if (wr_q && addr_q == PDC_ADDR_CHCTL) ch_m <= HWDATA[5:0];
      end
   end
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   ready_always_a: assert property (HREADYOUT)
      else $error("slave stalled");
   resp_okay_a: assert property (!HRESP)
      else $error("error response");
   reset_quiet_a: assert property ($fell(RST) |-> !PWM_OUT && !PWM_OE)
      else $error("pin active after reset");
   // latch then pin register: two edges behind the cleared control
   clear_low_a: assert property ((ch_m == 6'h00) [*3] |-> !PWM_OUT)
      else $error("pin high with control cleared");
   oe_mode_a: assert property ((ch_m[3:2] != PDC_MODE_PWM) [*2] |-> !PWM_OE)
      else $error("pin driven outside pwm mode");
   run_idle_a: assert property (!cnt_m[PDC_RUN_BIT] [*3] |-> !$rose(PWM_OUT))
      else $error("pin set with counter stopped");
   ctl_rsvd_a: assert property (rd_q && addr_q == PDC_ADDR_CHCTL |-> HRDATA[31:6] == '0)
      else $error("unused control bits read nonzero");
   duty_read_a: assert property (rd_q && addr_q == PDC_ADDR_DUTYHI |-> HRDATA == {24'h0, $past(du_m)})
      else $error("duty byte readback wrong");
   cover property ($rose(PWM_OUT));
   cover property ($fell(PWM_OUT));
   cover property (rd_q && addr_q == PDC_ADDR_DUTYHI);
endmodule
bind pdc_channel pdc_channel_sva chk (.REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PWM_OUT(PWM_OUT), .PWM_OE(PWM_OE));
`default_nettype wire

/* bench/tb.sv */
// self-checking testbench for the pwm duty cycle channel
`timescale 1ns/1ps
`default_nettype none
module tb
   import pdc_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, pwm, oe, hready;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [15:0] last_high;
   int n_errors = 0, tests_run = 0, hits;
   pdc_channel dut (.REF_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(), .PWM_OUT(pwm), .PWM_OE(oe));
   pdc_pin_model load (.clk(clk), .pin_out(pwm), .pin_oe(oe), .last_high(last_high));
   initial forever #50 clk = ~clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   // the address phase is held until ready, then data until ready again
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= PDC_HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, e);
      logic [31:0] r;
      xfer(1'b0, a, 8'h00, r);
      chk(r, {24'h0, e});
   endtask
   task automatic setup(input logic [7:0] lim, du, input logic [1:0] fr, ps);
      wr(PDC_ADDR_LIMIT, lim);
      wr(PDC_ADDR_DUTYHI, du);
      wr(PDC_ADDR_CHCTL, {2'h0, fr, 4'h0});
      wr(PDC_ADDR_PIN, 8'h00);
      wr(PDC_ADDR_CNTCTL, {5'h00, 1'b1, ps});
      wr(PDC_ADDR_CHCTL, {2'h0, fr, 4'hc});
   endtask
   task automatic t_regs;
      rd(PDC_ADDR_LIMIT, PDC_RST_LIMIT);
      rd(PDC_ADDR_COUNT, PDC_RST_BYTE);
      rd(8'h1c, 8'h00);
   endtask
   // duty 6 with fraction bits 10, every prescale code
   task automatic t_width;
      for (int i = 0; i < 4; i++) begin
         setup(8'h03, 8'h01, 2'h2, i[1:0]);
         repeat (800) @(posedge clk);
         chk({16'h0, last_high}, 6 * ((i == 0) ? 1 : (i == 1) ? 4 : 16));
      end
   endtask
   task automatic t_over;
      setup(8'h03, 8'h10, 2'h0, 2'h0);
      repeat (100) @(posedge clk);
      wr(PDC_ADDR_SHADOW, 8'h55);
      rd(PDC_ADDR_SHADOW, 8'h10);
      hits = 0;
      repeat (40) @(posedge clk) hits += (pwm === 1'b1);
      chk(hits, 40);
      wr(PDC_ADDR_CHCTL, 8'h00);
      repeat (3) @(posedge clk);
      chk({pwm, oe}, 2'b00);
      rd(PDC_ADDR_CHCTL, 8'h00);
   endtask
   // wait for a reload so the reads land well before the next one
   task automatic t_zero;
      setup(8'hff, 8'h20, 2'h0, 2'h0);
      for (int i = 0; i < 1100 && pwm !== 1'b1; i++) @(posedge clk);
      chk({31'h0, pwm}, 32'h1);
      wr(PDC_ADDR_DUTYHI, 8'h00);
      rd(PDC_ADDR_DUTYHI, 8'h00);
      rd(PDC_ADDR_SHADOW, 8'h20);
      repeat (1100) @(posedge clk);
      chk({16'h0, last_high}, 32'd128);
      rd(PDC_ADDR_SHADOW, 8'h00);
      hits = 0;
      repeat (1100) @(posedge clk) hits += (pwm === 1'b1);
      chk(hits, 0);
   endtask
   task automatic summarize;
      if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // about three times the expected run
   initial begin
      #2000000;
      n_errors++;
      summarize;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_width;
      t_over;
      t_zero;
      summarize;
   end
endmodule
`default_nettype wire
